// ===== shared/irq_mask_pkg.sv
/*
  Package for the regulator interrupt mask and identification registers:
  offsets, mask bit positions, reset values and shared types.
  Assumes a register access port driven by the serial control bus front end.
*/
`default_nettype none
package irq_mask_pkg;
  localparam int          DATA_WIDTH       = 8;
  localparam int          ADDR_WIDTH       = 8;
  localparam logic [7:0]  ADDR_MASK        = 8'h02;
  localparam logic [7:0]  ADDR_PRODUCT_ID  = 8'h03;
  localparam logic [7:0]  ADDR_REVISION_ID = 8'h04;
  localparam int          BIT_POWER_GOOD   = 0;
  localparam int          BIT_OVERCURRENT  = 1;
  localparam int          BIT_UNDERVOLTAGE = 2;
  localparam int          BIT_SHORT        = 3;
  localparam int          BIT_SPARE        = 4;
  localparam int          BIT_PREWARNING   = 5;
  localparam int          BIT_WARNING      = 6;
  localparam int          BIT_SHUTDOWN     = 7;
  // All sources masked after reset; spare bit reads as one
  localparam logic [7:0]  MASK_RESET       = 8'hff;
  localparam logic [7:0]  SPARE_ONES       = 8'h10;
  localparam logic [7:0]  READ_UNMAPPED    = 8'h00;
  // Arbitrary neutral identifier values
  localparam logic [7:0]  PRODUCT_ID_VALUE  = 8'h5a;
  localparam logic [7:0]  REVISION_ID_VALUE = 8'h0a;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
endpackage
`default_nettype wire

// ===== logic/event_latch.sv
/*
  One sticky event bit with its mask gate.
  Assumes event pulses and clears are synchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module event_latch (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic event_i,
  input  wire logic clear_i,
  input  wire logic block_i,
  output logic      latched_o,
  output logic      request_o
);
  logic next_latched;

  always_comb begin
    // Set wins over a simultaneous clear so no event is lost
    next_latched = event_i | (latched_o & ~clear_i);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched_o <= 1'b0;
    end else begin
      latched_o <= next_latched;
    end
  end

  assign request_o = latched_o & ~block_i;
endmodule
`default_nettype wire

// ===== logic/irq_mask_regs.sv
/*
  Interrupt mask register, product and revision identifiers, and the
  gated interrupt output. Event inputs are one per source in mask bit order.
  Assumes the bus front end delivers one-cycle read/write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_mask_regs
  import irq_mask_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID  = PRODUCT_ID_VALUE,
  parameter logic [7:0] REVISION_ID = REVISION_ID_VALUE
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire reg_req_type req_i,
  input  wire logic [7:0]  source_event_i,
  input  wire logic [7:0]  source_clear_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  output logic [7:0]       event_status_o,
  output logic             irq_o
);
  logic [7:0] interrupt_source_mask;
  logic [7:0] next_mask;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic [7:0] request;
  logic       next_irq;

  always_comb begin
    next_mask = interrupt_source_mask;
    if (req_i.write && req_i.addr == ADDR_MASK) begin
      next_mask = req_i.wdata | SPARE_ONES;
    end
  end

  always_comb begin
    next_rvalid = req_i.read;
    next_rdata  = rdata_o;
    if (req_i.read) begin
      case (req_i.addr)
        ADDR_MASK:        next_rdata = interrupt_source_mask;
        ADDR_PRODUCT_ID:  next_rdata = PRODUCT_ID;
        ADDR_REVISION_ID: next_rdata = REVISION_ID;
        default:          next_rdata = READ_UNMAPPED;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < DATA_WIDTH; g++) begin : g_src
      if (g == BIT_SPARE) begin : g_spare
        assign event_status_o[g] = 1'b0;
        assign request[g]        = 1'b0;
      end else begin : g_live
        // Each source gated by its mask bit: 1 blocks, 0 passes
        event_latch u_latch (
          .clock_i   (clock_i),
          .rst_n_i   (rst_n_i),
          .event_i   (source_event_i[g]),
          .clear_i   (source_clear_i[g]),
          .block_i   (interrupt_source_mask[g]),
          .latched_o (event_status_o[g]),
          .request_o (request[g])
        );
      end
    end
  endgenerate

  always_comb begin
    next_irq = |request;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_source_mask <= MASK_RESET;
      rdata_o               <= READ_UNMAPPED;
      rvalid_o              <= 1'b0;
      irq_o                 <= 1'b0;
    end else begin
      interrupt_source_mask <= next_mask;
      rdata_o               <= next_rdata;
      rvalid_o              <= next_rvalid;
      irq_o                 <= next_irq;
    end
  end

  // Gate checks: a masked source with no other source requesting keeps irq low; pass checks: an unmasked latched one raises it
  localparam logic [7:0] SINGLE_BIT   = 8'h01;
  localparam logic [7:0] NONE_PENDING = 8'h00;

  a_overcurrent_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_OVERCURRENT] && event_status_o[BIT_OVERCURRENT]
      && (request & ~(SINGLE_BIT << BIT_OVERCURRENT)) == NONE_PENDING |=> !irq_o)
    else $error("Masked over-current raised interrupt");

  a_overcurrent_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !interrupt_source_mask[BIT_OVERCURRENT] && event_status_o[BIT_OVERCURRENT] |=> irq_o)
    else $error("Unmasked over-current did not raise interrupt");

  a_undervolt_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_UNDERVOLTAGE] && event_status_o[BIT_UNDERVOLTAGE]
      && (request & ~(SINGLE_BIT << BIT_UNDERVOLTAGE)) == NONE_PENDING |=> !irq_o)
    else $error("Masked under-voltage raised interrupt");

  a_undervolt_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !interrupt_source_mask[BIT_UNDERVOLTAGE] && event_status_o[BIT_UNDERVOLTAGE] |=> irq_o)
    else $error("Unmasked under-voltage did not raise interrupt");

  a_warning_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_WARNING] && event_status_o[BIT_WARNING]
      && (request & ~(SINGLE_BIT << BIT_WARNING)) == NONE_PENDING |=> !irq_o)
    else $error("Masked thermal warning raised interrupt");

  a_warning_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !interrupt_source_mask[BIT_WARNING] && event_status_o[BIT_WARNING] |=> irq_o)
    else $error("Unmasked thermal warning did not raise interrupt");

  a_shutdown_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_SHUTDOWN] && event_status_o[BIT_SHUTDOWN]
      && (request & ~(SINGLE_BIT << BIT_SHUTDOWN)) == NONE_PENDING |=> !irq_o)
    else $error("Masked thermal shutdown raised interrupt");

  a_shutdown_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !interrupt_source_mask[BIT_SHUTDOWN] && source_event_i[BIT_SHUTDOWN]
      ##1 !interrupt_source_mask[BIT_SHUTDOWN] |=> irq_o)
    else $error("Unmasked thermal shutdown did not raise interrupt");

  a_powergood_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_POWER_GOOD] && event_status_o[BIT_POWER_GOOD]
      && (request & ~(SINGLE_BIT << BIT_POWER_GOOD)) == NONE_PENDING |=> !irq_o)
    else $error("Masked power good raised interrupt");

  a_short_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_SHORT] && event_status_o[BIT_SHORT]
      && (request & ~(SINGLE_BIT << BIT_SHORT)) == NONE_PENDING |=> !irq_o)
    else $error("Masked short circuit raised interrupt");

  a_prewarn_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_PREWARNING] && event_status_o[BIT_PREWARNING]
      && (request & ~(SINGLE_BIT << BIT_PREWARNING)) == NONE_PENDING |=> !irq_o)
    else $error("Masked thermal pre-warning raised interrupt");

  a_prewarn_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !interrupt_source_mask[BIT_PREWARNING] && event_status_o[BIT_PREWARNING] |=> irq_o)
    else $error("Unmasked thermal pre-warning did not raise interrupt");

  // Latch behaviour; masking must never stop an event from being recorded
  a_event_latches: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    source_event_i[BIT_OVERCURRENT] |=> event_status_o[BIT_OVERCURRENT])
    else $error("Event not recorded while masked or unmasked");

  a_shutdown_latch: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    source_event_i[BIT_SHUTDOWN] |=> event_status_o[BIT_SHUTDOWN])
    else $error("Thermal shutdown event not recorded");

  a_set_beats_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    source_event_i[BIT_OVERCURRENT] && source_clear_i[BIT_OVERCURRENT]
      |=> event_status_o[BIT_OVERCURRENT])
    else $error("Clear beat a simultaneous event");

  a_clear_drops: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    source_clear_i[BIT_OVERCURRENT] && !source_event_i[BIT_OVERCURRENT]
      |=> !event_status_o[BIT_OVERCURRENT])
    else $error("Over-current status not cleared");

  a_warning_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    source_clear_i[BIT_WARNING] && !source_event_i[BIT_WARNING]
      |=> !event_status_o[BIT_WARNING])
    else $error("Thermal warning status not cleared");

  a_status_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    event_status_o[BIT_UNDERVOLTAGE] && !source_clear_i[BIT_UNDERVOLTAGE]
      |=> event_status_o[BIT_UNDERVOLTAGE])
    else $error("Under-voltage status dropped without clear");

  a_spare_status: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !event_status_o[BIT_SPARE])
    else $error("Spare source recorded an event");

  // Interrupt output as a whole
  a_irq_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_o |-> $past(|(event_status_o & ~interrupt_source_mask)))
    else $error("Interrupt without unmasked latched event");

  a_irq_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    |(event_status_o & ~interrupt_source_mask) |=> irq_o)
    else $error("Unmasked latched event did not raise interrupt");

  a_no_spurious: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    event_status_o == NONE_PENDING |=> !irq_o)
    else $error("Interrupt raised with no latched event");

  // Register access
  a_mask_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.write && req_i.addr == ADDR_MASK
      |=> interrupt_source_mask == ($past(req_i.wdata) | SPARE_ONES))
    else $error("Mask write not stored");

  a_other_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(req_i.write && req_i.addr == ADDR_MASK) |=> $stable(interrupt_source_mask))
    else $error("Mask changed without a mask write");

  a_spare_mask: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    interrupt_source_mask[BIT_SPARE])
    else $error("Spare mask bit not one");

  a_id_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.read && req_i.addr == ADDR_PRODUCT_ID |=> rvalid_o && rdata_o == PRODUCT_ID)
    else $error("Product identifier read wrong");

  a_revision_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.read && req_i.addr == ADDR_REVISION_ID |=> rdata_o == REVISION_ID)
    else $error("Revision identifier read wrong");

  a_mask_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.read && req_i.addr == ADDR_MASK |=> rdata_o == $past(interrupt_source_mask))
    else $error("Mask read wrong");

  a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.read && req_i.addr != ADDR_MASK && req_i.addr != ADDR_PRODUCT_ID
      && req_i.addr != ADDR_REVISION_ID |=> rdata_o == READ_UNMAPPED)
    else $error("Unmapped read not zero");

  a_rvalid_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_i.read |=> rvalid_o)
    else $error("Read not answered one cycle later");

  a_rvalid_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !req_i.read |=> !rvalid_o)
    else $error("Read valid without a read");

  // Read data holds between reads so a slow host may pick it up late
  a_rdata_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !req_i.read |=> $stable(rdata_o))
    else $error("Read data changed without a read");
endmodule
`default_nettype wire

// ===== verification/reg_host_model.sv
/*
  Host model issuing register reads and writes.
  Assumes one clock; requests change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
  import irq_mask_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output var reg_req_type req_o
);
  initial req_o = '0;
  // Released lines show inverted values so stale data cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_o <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req_o <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

// ===== verification/regulator_irq_mask_and_id_regs_bench.sv
/*
  Bench for the mask and identifier registers.
  Assumes the host model drives requests; events come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module regulator_irq_mask_and_id_regs_bench;
  import irq_mask_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  reg_req_type req;
  logic [7:0]  ev = '0, clr = '0, rdata, status, d, m;
  logic        rvalid, irq, v;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  int          bits [7] = '{0, 1, 2, 3, 5, 6, 7};
  initial forever #2 clock_i = ~clock_i;
  irq_mask_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req),
    .source_event_i(ev), .source_clear_i(clr), .rdata_o(rdata),
    .rvalid_o(rvalid), .event_status_o(status), .irq_o(irq));
  reg_host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, d, v);
    check("rvalid", 8'h01, {7'h00, v});
    check("rdata", exp, d);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run needs well under 400 cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    read_check(ADDR_MASK, MASK_RESET);
    read_check(ADDR_PRODUCT_ID, PRODUCT_ID_VALUE);
    read_check(ADDR_REVISION_ID, REVISION_ID_VALUE);
    read_check(8'h07, READ_UNMAPPED);
    host.write_reg(ADDR_PRODUCT_ID, 8'h00);
    read_check(ADDR_PRODUCT_ID, PRODUCT_ID_VALUE);
    host.write_reg(ADDR_MASK, 8'h00);
    read_check(ADDR_MASK, SPARE_ONES);
    $display("test registers done");
    foreach (bits[i]) begin
      m = 8'h01 << bits[i];
      host.write_reg(ADDR_MASK, 8'hff);
      @(posedge clock_i) ev <= m;
      @(posedge clock_i) ev <= '0;
      repeat (2) @(posedge clock_i);
      #1;
      check("status", m, status);
      check("irq masked", 8'h00, {7'h00, irq});
      host.write_reg(ADDR_MASK, ~m);
      @(posedge clock_i);
      #1;
      check("irq enabled", 8'h01, {7'h00, irq});
      read_check(ADDR_MASK, ~m | SPARE_ONES);
      @(posedge clock_i) clr <= m;
      @(posedge clock_i) clr <= '0;
      @(posedge clock_i);
      #1;
      check("irq cleared", 8'h00, {7'h00, irq});
      $display("test source bit %0d done", bits[i]);
    end
    host.write_reg(ADDR_MASK, 8'h00);
    @(posedge clock_i) ev <= SPARE_ONES;
    @(posedge clock_i) ev <= '0;
    repeat (2) @(posedge clock_i);
    #1;
    check("spare status", 8'h00, status);
    check("spare irq", 8'h00, {7'h00, irq});
    @(posedge clock_i) begin
      ev  <= 8'h02;
      clr <= 8'h02;
    end
    @(posedge clock_i) begin
      ev  <= '0;
      clr <= '0;
    end
    @(posedge clock_i);
    #1;
    check("status set beats clear", 8'h02, status);
    check("irq after collision", 8'h01, {7'h00, irq});
    @(posedge clock_i) clr <= 8'h02;
    @(posedge clock_i) clr <= '0;
    @(posedge clock_i);
    #1;
    check("status cleared", 8'h00, status);
    $display("test spare and collision done");
    @(posedge clock_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    read_check(ADDR_MASK, MASK_RESET);
    check("irq after reset", 8'h00, {7'h00, irq});
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
